//--- hw/fabric_params.svh
`ifndef FABRIC_PARAMS_SVH
`define FABRIC_PARAMS_SVH

// endpoint kinds
`define KIND_AXI4        2'h0
`define KIND_AXI3        2'h1
`define KIND_NATIVE      2'h2
`define KIND_LITE        2'h3

// response codes
`define RESP_OKAY        2'h0
`define RESP_EXOKAY      2'h1
`define RESP_SLVERR      2'h2
`define RESP_DECERR      2'h3

// burst limits and fixed values
`define MAX_INCR_BEATS   9'h100
`define AXI3_MAX_BEATS   9'h010
`define NATIVE_MAX_BEATS 9'h008
`define QOS_NONE         4'h0
`define REGION_NONE      4'h0
`define BURST_FIXED      2'h0
`define CACHE_MOD_BIT    1
`define CACHE_LITE_MASK  4'hC

`endif

//--- hw/fabric_pkg.sv
package fabric_pkg;
  typedef logic [1:0] kind_t;
  typedef logic [1:0] resp_t;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_DATA = 5'h04,
    ST_RESP = 5'h08,
    ST_DONE = 5'h10
  } agent_state_t;
endpackage

//--- hw/fabric_agent.sv
`timescale 1ns/100ps
// Operation
// - accept incrementing bursts up to 256 beats
// - split long bursts to the burst limit
// - narrow bursts to native become single beats
// - cut to 16 beats for AXI3, AXI4 untouched
// - carry 4-bit qos, drop for qos-less slaves
// - AXI3 or native masters send zero qos
// - drive region outputs with zero
// - keep non-modifiable same-ID transactions in order
// - responses return in issue order
// - reordering slaves get constant ID, others real
// - responses only from final endpoint, write responses merged across sub-bursts
// - no packing; narrow beats stay separate commands
// - forward cache attributes unchanged, except lite keeps only bits 3:2
// - user sideband up to 64 bits
// - stream link is one-to-one, no adaptation
// - stream widths within documented bounds
// - lite accesses single, full width, no exclusive
// - lite width 32 or 64, full-size beats
// - store ID and reflect onto lite responses
// - bursts to lite reduced to length one
// - decode error outranks slave error when merging
`include "fabric_params.svh"

module fabric_agent
  import fabric_pkg::*;
#(
  parameter int    ID_W       = 4,
  parameter int    ADDR_W     = 32,
  parameter int    DATA_W     = 32,
  parameter int    USER_W     = 8,
  parameter kind_t MST_KIND   = `KIND_AXI4,
  parameter kind_t SLV_KIND   = `KIND_AXI4,
  parameter bit    SLV_QOS    = 1'b1,
  parameter bit    SLV_REORD  = 1'b0,
  parameter int    NATIVE_MAX = 8,
  parameter int    TDATA_W    = 32,
  parameter int    TID_W      = 4,
  parameter int    TDEST_W    = 2
) (
  input  wire logic                core_clk,
  input  wire logic                sys_rst,
  input  wire logic                mst_awvalid,
  output logic                     mst_awready,
  input  wire logic [ID_W-1:0]     mst_awid,
  input  wire logic [ADDR_W-1:0]   mst_awaddr,
  input  wire logic [7:0]          mst_awlen,
  input  wire logic [2:0]          mst_awsize,
  input  wire logic [1:0]          mst_awburst,
  input  wire logic                mst_awlock,
  input  wire logic [3:0]          mst_awcache,
  input  wire logic [2:0]          mst_awprot,
  input  wire logic [3:0]          mst_awqos,
  input  wire logic                mst_wvalid,
  output logic                     mst_wready,
  input  wire logic [DATA_W-1:0]   mst_wdata,
  input  wire logic [DATA_W/8-1:0] mst_wstrb,
  input  wire logic [USER_W-1:0]   mst_wuser,
  output logic                     mst_bvalid,
  input  wire logic                mst_bready,
  output logic [ID_W-1:0]          mst_bid,
  output logic [1:0]               mst_bresp,
  output logic [USER_W-1:0]        mst_buser,
  input  wire logic                mst_arvalid,
  output logic                     mst_arready,
  input  wire logic [ID_W-1:0]     mst_arid,
  input  wire logic [ADDR_W-1:0]   mst_araddr,
  input  wire logic [7:0]          mst_arlen,
  input  wire logic [2:0]          mst_arsize,
  input  wire logic [1:0]          mst_arburst,
  input  wire logic                mst_arlock,
  input  wire logic [3:0]          mst_arcache,
  input  wire logic [2:0]          mst_arprot,
  input  wire logic [3:0]          mst_arqos,
  output logic                     mst_rvalid,
  input  wire logic                mst_rready,
  output logic [ID_W-1:0]          mst_rid,
  output logic [DATA_W-1:0]        mst_rdata,
  output logic [1:0]               mst_rresp,
  output logic                     mst_rlast,
  output logic [USER_W-1:0]        mst_ruser,
  output logic                     slv_awvalid,
  input  wire logic                slv_awready,
  output logic                     slv_arvalid,
  input  wire logic                slv_arready,
  output logic [ID_W-1:0]          slv_id,
  output logic [ADDR_W-1:0]        slv_addr,
  output logic [7:0]               slv_len,
  output logic [2:0]               slv_size,
  output logic [1:0]               slv_burst,
  output logic                     slv_lock,
  output logic [3:0]               slv_cache,
  output logic [2:0]               slv_prot,
  output logic [3:0]               slv_qos,
  output logic [3:0]               slv_region,
  output logic                     slv_wvalid,
  input  wire logic                slv_wready,
  output logic [DATA_W-1:0]        slv_wdata,
  output logic [DATA_W/8-1:0]      slv_wstrb,
  output logic                     slv_wlast,
  output logic [USER_W-1:0]        slv_wuser,
  input  wire logic                slv_bvalid,
  output logic                     slv_bready,
  input  wire logic [1:0]          slv_bresp,
  input  wire logic [USER_W-1:0]   slv_buser,
  input  wire logic                slv_rvalid,
  output logic                     slv_rready,
  input  wire logic [DATA_W-1:0]   slv_rdata,
  input  wire logic [1:0]          slv_rresp,
  input  wire logic                slv_rlast,
  input  wire logic [USER_W-1:0]   slv_ruser,
  input  wire logic                src_tvalid,
  output logic                     src_tready,
  input  wire logic [TDATA_W-1:0]  src_tdata,
  input  wire logic [TID_W-1:0]    src_tid,
  input  wire logic [TDEST_W-1:0]  src_tdest,
  input  wire logic                src_tlast,
  output logic                     dst_tvalid,
  input  wire logic                dst_tready,
  output logic [TDATA_W-1:0]       dst_tdata,
  output logic [TID_W-1:0]         dst_tid,
  output logic [TDEST_W-1:0]       dst_tdest,
  output logic                     dst_tlast
);

  localparam logic [2:0] FULL_SIZE = 3'($clog2(DATA_W/8));
  localparam logic [8:0] NAT_MAX   = 9'(NATIVE_MAX);

  agent_state_t      state_reg;
  logic              is_wr_reg;
  logic [ID_W-1:0]   id_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [8:0]        rem_reg;
  logic [8:0]        sub_reg;
  logic [8:0]        beat_reg;
  logic [2:0]        size_reg;
  logic [1:0]        burst_reg;
  logic              lock_reg;
  logic [3:0]        cache_reg;
  logic [2:0]        prot_reg;
  logic [3:0]        qos_reg;
  resp_t             resp_reg;
  logic [USER_W-1:0] buser_reg;
  logic              last_sub;
  logic              take_aw;
  logic              take_ar;
  logic [8:0]        sub_next;

  function automatic logic [8:0] min9(input logic [8:0] a, input logic [8:0] b);
    min9 = (a < b) ? a : b;
  endfunction

  function automatic logic [8:0] sub_len(input logic [8:0] rem, input logic [2:0] size);
    case (SLV_KIND)
      `KIND_AXI3:   sub_len = min9(rem, `AXI3_MAX_BEATS);
      `KIND_NATIVE: sub_len = (size < FULL_SIZE) ? 9'h001 : min9(rem, NAT_MAX);
      `KIND_LITE:   sub_len = 9'h001;
      default:      sub_len = rem;
    endcase
  endfunction

  function automatic resp_t merge(input resp_t a, input resp_t b);
    if (a == `RESP_DECERR || b == `RESP_DECERR) begin
      merge = `RESP_DECERR;
    end else if (a == `RESP_SLVERR || b == `RESP_SLVERR) begin
      merge = `RESP_SLVERR;
    end else if (a == `RESP_OKAY || b == `RESP_OKAY) begin
      merge = `RESP_OKAY;
    end else begin
      merge = `RESP_EXOKAY;
    end
  endfunction

  // one transaction in flight at a time keeps order per master and per ID
  assign take_ar     = (state_reg == ST_IDLE) && mst_arvalid;
  assign take_aw     = (state_reg == ST_IDLE) && mst_awvalid && !mst_arvalid;
  assign mst_arready = take_ar;
  assign mst_awready = take_aw;
  assign last_sub    = (rem_reg == sub_reg);
  assign sub_next    = sub_len(rem_reg, size_reg);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: if (take_ar || take_aw) state_reg <= ST_ADDR;
        ST_ADDR: if ((slv_awvalid && slv_awready) || (slv_arvalid && slv_arready)) state_reg <= ST_DATA;
        ST_DATA: begin
          if (is_wr_reg && slv_wvalid && slv_wready && slv_wlast) begin
            state_reg <= ST_RESP;
          end else if (!is_wr_reg && slv_rvalid && slv_rready && slv_rlast) begin
            state_reg <= last_sub ? ST_IDLE : ST_ADDR;
          end
        end
        ST_RESP: if (slv_bvalid) state_reg <= last_sub ? ST_DONE : ST_ADDR;
        ST_DONE: if (mst_bready) state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // command capture
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      is_wr_reg <= 1'b0;
      id_reg    <= '0;
      size_reg  <= 3'h0;
      burst_reg <= 2'h0;
      lock_reg  <= 1'b0;
      cache_reg <= 4'h0;
      prot_reg  <= 3'h0;
      qos_reg   <= `QOS_NONE;
    end else if (take_ar || take_aw) begin
      is_wr_reg <= take_aw;
      id_reg    <= take_ar ? mst_arid : mst_awid;
      size_reg  <= (SLV_KIND == `KIND_LITE) ? FULL_SIZE : (take_ar ? mst_arsize : mst_awsize);
      burst_reg <= take_ar ? mst_arburst : mst_awburst;
      lock_reg  <= (SLV_KIND == `KIND_LITE) ? 1'b0 : (take_ar ? mst_arlock : mst_awlock);
      cache_reg <= take_ar ? mst_arcache : mst_awcache;
      prot_reg  <= take_ar ? mst_arprot : mst_awprot;
      qos_reg   <= (MST_KIND == `KIND_AXI4) ? (take_ar ? mst_arqos : mst_awqos) : `QOS_NONE;
    end
  end

  // burst progress and address stepping
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      addr_reg <= '0;
      rem_reg  <= 9'h000;
      sub_reg  <= 9'h000;
    end else if (take_ar || take_aw) begin
      addr_reg <= take_ar ? mst_araddr : mst_awaddr;
      rem_reg  <= 9'(take_ar ? mst_arlen : mst_awlen) + 9'h001;
      sub_reg  <= 9'h000;
    end else if (state_reg == ST_IDLE || (state_reg == ST_ADDR && sub_reg == 9'h000)) begin
      sub_reg <= sub_next;
    end else if ((state_reg == ST_DATA && !is_wr_reg && slv_rvalid && slv_rready && slv_rlast && !last_sub) ||
                 (state_reg == ST_RESP && slv_bvalid && !last_sub)) begin
      rem_reg <= rem_reg - sub_reg;
      sub_reg <= 9'h000;
      if (burst_reg != `BURST_FIXED) begin
        addr_reg <= addr_reg + ADDR_W'({sub_reg, 7'h00} >> (3'h7 - size_reg));
      end
    end
  end

  // beat count within the current sub-burst
  always_ff @(posedge core_clk) begin
    if (sys_rst || state_reg == ST_ADDR) begin
      beat_reg <= 9'h000;
    end else if ((slv_wvalid && slv_wready) || (slv_rvalid && slv_rready)) begin
      beat_reg <= beat_reg + 9'h001;
    end
  end

  // write response merged across all sub-bursts
  always_ff @(posedge core_clk) begin
    if (sys_rst || take_aw) begin
      resp_reg  <= `RESP_EXOKAY;
      buser_reg <= '0;
    end else if (state_reg == ST_RESP && slv_bvalid) begin
      resp_reg  <= merge(resp_reg, slv_bresp);
      buser_reg <= slv_buser;
    end
  end

  // slave address channel
  assign slv_awvalid = (state_reg == ST_ADDR) && is_wr_reg && (sub_reg != 9'h000);
  assign slv_arvalid = (state_reg == ST_ADDR) && !is_wr_reg && (sub_reg != 9'h000);
  assign slv_id      = SLV_REORD ? '0 : id_reg;
  assign slv_addr    = addr_reg;
  assign slv_len     = 8'(sub_reg - 9'h001);
  assign slv_size    = size_reg;
  assign slv_burst   = burst_reg;
  assign slv_lock    = lock_reg;
  assign slv_cache   = (SLV_KIND == `KIND_LITE) ? (cache_reg & `CACHE_LITE_MASK) : cache_reg;
  assign slv_prot    = prot_reg;
  assign slv_qos     = SLV_QOS ? qos_reg : `QOS_NONE;
  assign slv_region  = `REGION_NONE;

  // write data path
  assign slv_wvalid = (state_reg == ST_DATA) && is_wr_reg && mst_wvalid;
  assign mst_wready = (state_reg == ST_DATA) && is_wr_reg && slv_wready;
  assign slv_wdata  = mst_wdata;
  assign slv_wstrb  = mst_wstrb;
  assign slv_wuser  = mst_wuser;
  assign slv_wlast  = (beat_reg == sub_reg - 9'h001);
  assign slv_bready = (state_reg == ST_RESP);

  // write response back to master, only after the final endpoint answered
  assign mst_bvalid = (state_reg == ST_DONE);
  assign mst_bid    = id_reg;
  assign mst_bresp  = resp_reg;
  assign mst_buser  = buser_reg;

  // read data path
  assign mst_rvalid = (state_reg == ST_DATA) && !is_wr_reg && slv_rvalid;
  assign slv_rready = (state_reg == ST_DATA) && !is_wr_reg && mst_rready;
  assign mst_rid    = id_reg;
  assign mst_rdata  = slv_rdata;
  assign mst_rresp  = slv_rresp;
  assign mst_rlast  = slv_rlast && last_sub;
  assign mst_ruser  = slv_ruser;

  // stream link: one source to one sink, no adaptation
  assign dst_tvalid = src_tvalid;
  assign src_tready = dst_tready;
  assign dst_tdata  = src_tdata;
  assign dst_tid    = src_tid;
  assign dst_tdest  = src_tdest;
  assign dst_tlast  = src_tlast;

endmodule

//--- tb/fabric_agent_props.sv
`timescale 1ns/100ps
`include "fabric_params.svh"
module fabric_agent_props #(
  parameter int ID_W   = 4,
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32,
  parameter int USER_W = 8
) (
  input wire logic              core_clk,
  input wire logic              sys_rst,
  input wire logic              mst_awvalid,
  input wire logic              mst_awready,
  input wire logic [ID_W-1:0]   mst_awid,
  input wire logic [3:0]        mst_awqos,
  input wire logic              mst_arvalid,
  input wire logic              mst_arready,
  input wire logic [3:0]        mst_arcache,
  input wire logic [ADDR_W-1:0] mst_araddr,
  input wire logic [2:0]        mst_arsize,
  input wire logic [1:0]        mst_arburst,
  input wire logic [2:0]        mst_arprot,
  input wire logic              mst_bvalid,
  input wire logic [USER_W-1:0] mst_buser,
  input wire logic [1:0]        mst_rresp,
  input wire logic [USER_W-1:0] mst_ruser,
  input wire logic [USER_W-1:0] mst_wuser,
  input wire logic              mst_rvalid,
  input wire logic [DATA_W-1:0] mst_rdata,
  input wire logic [DATA_W-1:0] mst_wdata,
  input wire logic              slv_awvalid,
  input wire logic              slv_arvalid,
  input wire logic [ID_W-1:0]   slv_id,
  input wire logic [7:0]        slv_len,
  input wire logic [3:0]        slv_cache,
  input wire logic [3:0]        slv_qos,
  input wire logic [3:0]        slv_region,
  input wire logic              slv_wvalid,
  input wire logic [DATA_W-1:0] slv_wdata,
  input wire logic              slv_rvalid,
  input wire logic [DATA_W-1:0] slv_rdata,
  input wire logic [ADDR_W-1:0] slv_addr,
  input wire logic [2:0]        slv_size,
  input wire logic [1:0]        slv_burst,
  input wire logic [2:0]        slv_prot,
  input wire logic [USER_W-1:0] slv_wuser,
  input wire logic              slv_bvalid,
  input wire logic              slv_bready,
  input wire logic [USER_W-1:0] slv_buser,
  input wire logic [1:0]        slv_rresp,
  input wire logic [USER_W-1:0] slv_ruser
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_aw_take;
    mst_awvalid && mst_awready;
  endsequence
  sequence s_ar_take;
    mst_arvalid && mst_arready;
  endsequence
  a_sub_len_cap: assert property ((slv_awvalid || slv_arvalid) |-> slv_len <= 8'h0F)
    else $error("sub-burst longer than 16 beats");
  a_region_zero: assert property ((slv_awvalid || slv_arvalid) |-> slv_region == `REGION_NONE)
    else $error("region not zero");
  a_qos_pass: assert property (s_aw_take |-> ##2 slv_awvalid && slv_qos == $past(mst_awqos, 2))
    else $error("qos altered");
  a_id_pass: assert property (s_aw_take |-> ##2 slv_id == $past(mst_awid, 2))
    else $error("id altered");
  a_cache_pass: assert property (s_ar_take |-> ##2 slv_arvalid && slv_cache == $past(mst_arcache, 2))
    else $error("cache altered");
  a_rdata_from_end: assert property (mst_rvalid |-> slv_rvalid && mst_rdata == slv_rdata)
    else $error("read data not from slave");
  a_wdata_no_pack: assert property (slv_wvalid |-> slv_wdata == mst_wdata)
    else $error("write data altered");
  a_resp_in_order: assert property (mst_bvalid |-> !mst_awready && !mst_arready)
    else $error("new command before response");
  a_addr_pass: assert property (s_ar_take |-> ##2 slv_addr == $past(mst_araddr, 2))
    else $error("address altered");
  a_attr_pass: assert property (s_ar_take |-> ##2 slv_prot == $past(mst_arprot, 2) &&
                                slv_size == $past(mst_arsize, 2) && slv_burst == $past(mst_arburst, 2))
    else $error("attributes altered");
  a_rresp_pass: assert property (mst_rvalid |-> mst_rresp == slv_rresp)
    else $error("read response altered");
  a_ruser_pass: assert property (mst_rvalid |-> mst_ruser == slv_ruser)
    else $error("read user altered");
  a_wuser_pass: assert property (slv_wvalid |-> slv_wuser == mst_wuser)
    else $error("write user altered");
  a_buser_pass: assert property (slv_bvalid && slv_bready |=> mst_buser == $past(slv_buser))
    else $error("response user altered");
endmodule

//--- tb/axi_slave_model.sv
`timescale 1ns/100ps
module axi_slave_model #(
  parameter int DATA_W = 32,
  parameter int USER_W = 8
) (
  input wire logic              core_clk,
  input wire logic              sys_rst,
  input wire logic              slow,
  input wire logic [1:0]        resp_sel,
  input wire logic              slv_awvalid,
  output logic                  slv_awready,
  input wire logic              slv_arvalid,
  output logic                  slv_arready,
  input wire logic [7:0]        slv_len,
  input wire logic              slv_wvalid,
  output logic                  slv_wready,
  input wire logic              slv_wlast,
  output logic                  slv_bvalid,
  input wire logic              slv_bready,
  output logic [1:0]            slv_bresp,
  output logic [USER_W-1:0]     slv_buser,
  output logic                  slv_rvalid,
  input wire logic              slv_rready,
  output logic [DATA_W-1:0]     slv_rdata,
  output logic [1:0]            slv_rresp,
  output logic                  slv_rlast,
  output logic [USER_W-1:0]     slv_ruser
);
  logic [7:0]        left_reg;
  logic              rd_reg;
  logic              wr_reg;
  logic [1:0]        cnt_reg;
  logic [DATA_W-1:0] pat_reg;
  logic              go;
  assign go         = !slow || cnt_reg == 2'h3;
  assign slv_rvalid = rd_reg && go;
  assign slv_rlast  = left_reg == 8'h00;
  assign slv_wready = wr_reg && go;
  assign slv_rdata  = pat_reg;
  assign slv_ruser  = pat_reg[USER_W-1:0];
  assign slv_buser  = pat_reg[USER_W-1:0];
  assign slv_bresp  = resp_sel;
  assign slv_rresp  = 2'h0;
  // pattern changes every cycle
  always_ff @(posedge core_clk) begin
    cnt_reg <= sys_rst ? 2'h0 : cnt_reg + 2'h1;
    pat_reg <= sys_rst ? '0 : {pat_reg[DATA_W-2:0], ~pat_reg[DATA_W-1]};
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      slv_arready <= 1'h0;
      slv_awready <= 1'h0;
      rd_reg      <= 1'h0;
      wr_reg      <= 1'h0;
      slv_bvalid  <= 1'h0;
      left_reg    <= 8'h00;
    end else begin
      slv_arready <= slv_arvalid && !slv_arready && go;
      slv_awready <= slv_awvalid && !slv_awready && go;
      if (slv_arvalid && slv_arready) begin
        rd_reg   <= 1'h1;
        left_reg <= slv_len;
      end else if (slv_rvalid && slv_rready) begin
        rd_reg   <= !slv_rlast;
        left_reg <= left_reg - 8'h01;
      end
      if (slv_awvalid && slv_awready) wr_reg <= 1'h1;
      else if (slv_wvalid && slv_wready && slv_wlast) wr_reg <= 1'h0;
      if (slv_wvalid && slv_wready && slv_wlast) slv_bvalid <= 1'h1;
      else if (slv_bready) slv_bvalid <= 1'h0;
    end
  end
endmodule

//--- tb/axi4_interconnect_adaptation_tb.sv
`timescale 1ns/100ps
`include "fabric_params.svh"
module axi4_interconnect_adaptation_tb;
  logic core_clk, sys_rst, slow, mst_awvalid, mst_awready, mst_awlock, mst_wvalid, mst_wready, mst_bvalid;
  logic mst_bready, mst_arvalid, mst_arready, mst_arlock, mst_rvalid, mst_rready, mst_rlast, slv_awvalid;
  logic slv_awready, slv_arvalid, slv_arready, slv_lock, slv_wvalid, slv_wready, slv_wlast, slv_bvalid;
  logic slv_bready, slv_rvalid, slv_rready, slv_rlast, src_tvalid, src_tready, src_tlast, dst_tvalid;
  logic dst_tready, dst_tlast;
  logic [3:0] mst_awid, mst_arid, mst_awcache, mst_arcache, mst_awqos, mst_arqos, mst_bid, mst_rid, slv_id;
  logic [3:0] slv_cache, slv_qos, slv_region, src_tid, dst_tid, mst_wstrb, slv_wstrb;
  logic [31:0] mst_awaddr, mst_araddr, mst_wdata, mst_rdata, slv_addr, slv_wdata, slv_rdata, src_tdata, dst_tdata;
  logic [7:0] mst_awlen, mst_arlen, slv_len, mst_wuser, mst_buser, mst_ruser, slv_wuser, slv_buser, slv_ruser;
  logic [2:0] mst_awsize, mst_arsize, mst_awprot, mst_arprot, slv_size, slv_prot;
  logic [1:0] mst_awburst, mst_arburst, mst_bresp, mst_rresp, slv_burst, slv_bresp, slv_rresp, src_tdest, dst_tdest;
  logic [1:0] resp_sel, resp_nx;
  logic [15:0] rnd = 16'h0055;
  logic [7:0] lens [6] = '{8'h00, 8'h0F, 8'h10, 8'h1F, 8'hFF, 8'h2A};
  logic [3:0] errs [6] = '{4'h2, 4'hE, 4'hB, 4'h8, 4'h6, 4'hC};
  int error_cnt;
  int n_compared;
  int subs;

  fabric_agent #(.SLV_KIND(`KIND_AXI3)) i_fabric_agent (.*);
  axi_slave_model i_axi_slave_model (.*);

  initial begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic int rank(input logic [1:0] r);
    return r == `RESP_DECERR ? 3 : r == `RESP_SLVERR ? 2 : r == `RESP_OKAY ? 1 : 0;
  endfunction
  always @(posedge core_clk) rnd <= lfsr(rnd);
  always @(posedge core_clk) if (slv_bvalid && slv_bready) resp_sel <= resp_nx;
  always @(posedge core_clk) if (slv_awvalid && slv_awready || slv_arvalid && slv_arready) subs++;

  task automatic stop_test;
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wait_hi(ref logic s);
    int k;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (s !== 1'h1 && k < 3000);
    if (s !== 1'h1) begin
      error_cnt++;
      $display("[ERR] %0t wait timed out", $time);
      stop_test();
    end
  endtask
  task automatic do_read(input logic [7:0] len);
    logic [3:0] id;
    int n;
    id = rnd[3:0];
    subs = 0;
    n = 0;
    mst_arvalid <= 1'h1;
    mst_arid <= id;
    mst_araddr <= {rnd, 16'h0000};
    mst_arlen <= len;
    mst_arsize <= rnd[1:0] == 2'h3 ? 3'h2 : {1'h0, rnd[1:0]};
    mst_arcache <= rnd[7:4];
    mst_arprot <= rnd[10:8];
    mst_arqos <= rnd[15:12];
    mst_rready <= 1'h1;
    wait_hi(mst_arready);
    mst_arvalid <= 1'h0;
    do begin
      wait_hi(mst_rvalid);
      n++;
    end while (mst_rlast !== 1'h1 && n < 300);
    mst_rready <= 1'h0;
    check(n, len + 1);
    check(mst_rid, id);
    check(subs, len / 16 + 1);
    $display("read len %0d done", len);
  endtask
  task automatic do_write(input logic [7:0] len, input logic [3:0] e);
    logic [3:0] id;
    logic [1:0] exp;
    id = rnd[3:0];
    subs = 0;
    exp = (len > 8'h0F && rank(e[1:0]) > rank(e[3:2])) ? e[1:0] : e[3:2];
    resp_sel <= e[3:2];
    resp_nx <= e[1:0];
    mst_awvalid <= 1'h1;
    mst_awid <= id;
    mst_awaddr <= {rnd, 16'h0000};
    mst_awlen <= len;
    mst_awcache <= rnd[7:4];
    mst_awprot <= rnd[10:8];
    mst_awqos <= rnd[15:12];
    wait_hi(mst_awready);
    mst_awvalid <= 1'h0;
    for (int i = 0; i <= len; i++) begin
      mst_wvalid <= 1'h1;
      mst_wdata <= {rnd, ~rnd};
      mst_wstrb <= rnd[3:0];
      mst_wuser <= rnd[7:0];
      wait_hi(mst_wready);
    end
    mst_wvalid <= 1'h0;
    mst_bready <= 1'h1;
    wait_hi(mst_bvalid);
    mst_bready <= 1'h0;
    check(mst_bresp, exp);
    check(mst_bid, id);
    check(subs, len / 16 + 1);
    $display("write len %0d done", len);
  endtask

  initial begin
    {mst_awvalid, mst_awid, mst_awaddr, mst_awlen, mst_awcache, mst_awprot, mst_awqos} = '0;
    {mst_arvalid, mst_arid, mst_araddr, mst_arlen, mst_arsize, mst_arcache, mst_arprot, mst_arqos} = '0;
    {mst_wvalid, mst_wdata, mst_wstrb, mst_wuser, mst_bready, mst_rready, slow, resp_sel, resp_nx} = '0;
    {src_tvalid, src_tdata, src_tid, src_tdest, src_tlast, dst_tready} = '0;
    {mst_awlock, mst_arlock} = 2'h0;
    {mst_awsize, mst_awburst, mst_arburst} = {3'h2, 2'h1, 2'h1};
    sys_rst = 1'h1;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'h0;
    foreach (lens[i]) begin
      slow <= i[0];
      do_read(lens[i]);
      do_write(lens[i], errs[i]);
    end
    repeat (6) begin
      slow <= rnd[6];
      do_write(rnd[5:0], rnd[11:8]);
      do_read(rnd[13:6]);
    end
    repeat (20) begin
      {src_tvalid, src_tdata, src_tid, src_tdest, src_tlast, dst_tready} <= {rnd, rnd, rnd[8:0]};
      @(posedge core_clk);
      check({dst_tvalid, dst_tdata, dst_tid, dst_tdest, dst_tlast, src_tready},
            {src_tvalid, src_tdata, src_tid, src_tdest, src_tlast, dst_tready});
    end
    $display("stream done");
    sys_rst <= 1'h1;
    @(posedge core_clk);
    sys_rst <= 1'h0;
    @(posedge core_clk);
    check({mst_bvalid, slv_awvalid, slv_arvalid, mst_bid}, 7'h00);
    do_write(8'h20, 4'h2);
    stop_test();
  end
endmodule

bind fabric_agent fabric_agent_props #(.ID_W(ID_W), .ADDR_W(ADDR_W), .DATA_W(DATA_W), .USER_W(USER_W))
  i_fabric_agent_props (.*);
